// *** hw/boundary_scan_test_port.v ***
// Functional notes
// - Three-bit instruction register, loaded serially from test data in.
// - Instruction picks the data register on the serial path and the test feature.
// - Code 000: shift boundary register, drive its values onto output pads.
// - Code 001: preload boundary register, capture live pad values for shifting.
// - Code 101: float all pads, freeze internal clocks, PLLs to low power.
// - In high-impedance mode the line transceivers keep running at full power.
// - Code 110: continuity mode for production testing.
// - Code 111: one-bit bypass register between test data in and out.
// - In bypass, test logic activity never disturbs normal device behaviour.
// - Reset clears the test logic and selects bypass automatically.
// - One-bit bypass register forms the path when no other register selected.
// - Test data in and mode select read as one when left open.
// - Serial port is test clock, data in, data out and mode select.
// - Full standard sixteen-state test access port controller.
// - Boundary register holds pad cells and an output-enable cell driving on one.
`timescale 1ns/1ns
`include "boundary_scan_test_port_defines.vh"

module boundary_scan_test_port (
	// System clock and reset
	clk,
	rst,
	// Serial test port
	tck,
	tms,
	tdi,
	tdo,
	tdoOeN,
	// Functional pad signals from and to the core
	coreOut,
	coreOeN,
	pinIn,
	padOut,
	padOeN,
	// Test mode controls to the rest of the chip
	clockFreeze,
	pllLowPower,
	lineTransceiversOn,
	continuityMode
);

	input  wire                 clk;
	input  wire                 rst;
	input  wire                 tck;
	input  wire                 tms;
	input  wire                 tdi;
	output reg                  tdo;
	output reg                  tdoOeN;
	input  wire [`PADS-1:0]     coreOut;
	input  wire                 coreOeN;
	input  wire [`PADS-1:0]     pinIn;
	output reg  [`PADS-1:0]     padOut;
	output reg                  padOeN;
	output reg                  clockFreeze;
	output reg                  pllLowPower;
	output wire                 lineTransceiversOn;
	output reg                  continuityMode;

	// ***************************************************************
	// Controller states
	// ***************************************************************
	localparam [15:0] ST_RESET = 16'h0001;
	localparam [15:0] ST_IDLE  = 16'h0002;
	localparam [15:0] ST_SELDR = 16'h0004;
	localparam [15:0] ST_CAPDR = 16'h0008;
	localparam [15:0] ST_SHDR  = 16'h0010;
	localparam [15:0] ST_EX1DR = 16'h0020;
	localparam [15:0] ST_PADR  = 16'h0040;
	localparam [15:0] ST_EX2DR = 16'h0080;
	localparam [15:0] ST_UPDR  = 16'h0100;
	localparam [15:0] ST_SELIR = 16'h0200;
	localparam [15:0] ST_CAPIR = 16'h0400;
	localparam [15:0] ST_SHIR  = 16'h0800;
	localparam [15:0] ST_EX1IR = 16'h1000;
	localparam [15:0] ST_PAIR  = 16'h2000;
	localparam [15:0] ST_EX2IR = 16'h4000;
	localparam [15:0] ST_UPIR  = 16'h8000;

	wire                 tckLevel;
	wire                 tmsLevel;
	wire                 tdiLevel;
	reg                  tckPrev_q;
	reg  [15:0]          state_q;
	reg  [15:0]          state_d;
	reg  [`IR_WIDTH-1:0] irShift_q;
	reg  [`IR_WIDTH-1:0] ir_q;
	reg                  bypass_q;
	reg  [`BSR_LEN-1:0]  bsrShift_q;
	reg  [`BSR_LEN-1:0]  bsrHold_q;
	wire                 tckRise;
	wire                 tckFall;
	wire                 selExtest;
	wire                 selSample;
	wire                 selHighz;
	wire                 selBsr;
	wire [`BSR_LEN-1:0]  bsrCapture;
	wire [`PADS-1:0]     pinLevel;

	// ***************************************************************
	// Pin sampling
	// ***************************************************************
	// Test clock runs far slower than clk, so it is sampled like any pin
	pin_sync3 #(.RESET_LEVEL(`BIT_CLEAR)) tckSync (
		.clk   (clk),
		.rst   (rst),
		.pin   (tck),
		.level (tckLevel)
	);

	// pulled-up inputs
	// Undriven mode select and data in rest high, so five clocks reach reset
	pin_sync3 #(.RESET_LEVEL(`PULLUP_LEVEL)) tmsSync (
		.clk   (clk),
		.rst   (rst),
		.pin   (tms),
		.level (tmsLevel)
	);

	pin_sync3 #(.RESET_LEVEL(`PULLUP_LEVEL)) tdiSync (
		.clk   (clk),
		.rst   (rst),
		.pin   (tdi),
		.level (tdiLevel)
	);

	// Live pad levels are asynchronous, so each bit is filtered before capture
	genvar padIdx;
	generate
		for (padIdx = 0; padIdx < `PADS; padIdx = padIdx + 1) begin : padSync
			pin_sync3 #(.RESET_LEVEL(`BIT_CLEAR)) pinInSync (
				.clk   (clk),
				.rst   (rst),
				.pin   (pinIn[padIdx]),
				.level (pinLevel[padIdx])
			);
		end
	endgenerate

	// edge detection
	// All three pins see the same delay, so data is stable at each edge
	assign tckRise = tckLevel & ~tckPrev_q;
	assign tckFall = ~tckLevel & tckPrev_q;

	// ***************************************************************
	// Instruction decode
	// ***************************************************************
	// register selection
	assign selExtest = (ir_q == `IR_EXTEST);
	assign selSample = (ir_q == `IR_SAMPLE);
	assign selHighz  = (ir_q == `IR_HIGHZ);
	// reserved as bypass
	// Any code other than extest or sample keeps the bypass cell in the path
	assign selBsr    = selExtest | selSample;

	// capture of live pads, core outputs and the enable cell
	assign bsrCapture = {~coreOeN, coreOut, pinLevel};

	// ***************************************************************
	// Controller next state
	// ***************************************************************
	// standard state walk
	always @* begin
		case (state_q)
			ST_RESET: state_d = tmsLevel ? ST_RESET : ST_IDLE;
			ST_IDLE:  state_d = tmsLevel ? ST_SELDR : ST_IDLE;
			ST_SELDR: state_d = tmsLevel ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: state_d = tmsLevel ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  state_d = tmsLevel ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: state_d = tmsLevel ? ST_UPDR  : ST_PADR;
			ST_PADR:  state_d = tmsLevel ? ST_EX2DR : ST_PADR;
			ST_EX2DR: state_d = tmsLevel ? ST_UPDR  : ST_SHDR;
			ST_UPDR:  state_d = tmsLevel ? ST_SELDR : ST_IDLE;
			ST_SELIR: state_d = tmsLevel ? ST_RESET : ST_CAPIR;
			ST_CAPIR: state_d = tmsLevel ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  state_d = tmsLevel ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: state_d = tmsLevel ? ST_UPIR  : ST_PAIR;
			ST_PAIR:  state_d = tmsLevel ? ST_EX2IR : ST_PAIR;
			ST_EX2IR: state_d = tmsLevel ? ST_UPIR  : ST_SHIR;
			ST_UPIR:  state_d = tmsLevel ? ST_SELDR : ST_IDLE;
			default:  state_d = ST_RESET;
		endcase
	end

	// ***************************************************************
	// Rising test clock: state, capture and shift
	// ***************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tckPrev_q  <= `BIT_CLEAR;
			state_q    <= ST_RESET;
			irShift_q  <= `IR_BYPASS;
			bypass_q   <= `BYPASS_CAPTURE;
			bsrShift_q <= {`BSR_LEN{`BIT_CLEAR}};
		end else begin
			tckPrev_q <= tckLevel;
			if (tckRise) begin
				state_q <= state_d;
				if (state_q == ST_CAPIR) begin
					irShift_q <= `IR_CAPTURE;
				end else if (state_q == ST_SHIR) begin
					irShift_q <= {tdiLevel, irShift_q[`IR_WIDTH-1:1]};
				end
				if (state_q == ST_CAPDR) begin
					bypass_q <= `BYPASS_CAPTURE;
				end else if (state_q == ST_SHDR) begin
					bypass_q <= tdiLevel;
				end
				if (selBsr && state_q == ST_CAPDR) begin
					bsrShift_q <= bsrCapture;
				end else if (selBsr && state_q == ST_SHDR) begin
					bsrShift_q <= {tdiLevel, bsrShift_q[`BSR_LEN-1:1]};
				end
			end
		end
	end

	// ***************************************************************
	// Falling test clock: updates and data out
	// ***************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ir_q      <= `IR_BYPASS;
			bsrHold_q <= {`BSR_LEN{`BIT_CLEAR}};
			tdo       <= `TDO_IDLE;
			tdoOeN    <= `OE_OFF;
		end else if (tckFall) begin
			if (state_q == ST_RESET) begin
				ir_q <= `IR_BYPASS;
			end else if (state_q == ST_UPIR) begin
				ir_q <= irShift_q;
			end
			// preload lands in the hold stage, ready for a later extest
			if (selBsr && state_q == ST_UPDR) begin
				bsrHold_q <= bsrShift_q;
			end
			// data out drives only while shifting, else it floats
			if (state_q == ST_SHIR) begin
				tdo <= irShift_q[0];
			end else if (state_q == ST_SHDR) begin
				// bypass cell on the path unless a boundary code is live
				tdo <= selBsr ? bsrShift_q[0] : bypass_q;
			end else begin
				tdo <= `TDO_IDLE;
			end
			tdoOeN <= ~(state_q == ST_SHIR || state_q == ST_SHDR);
		end
	end

	// ***************************************************************
	// Pad and chip control outputs
	// ***************************************************************
	// Registered once more so pads never glitch on decode changes
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			padOut         <= {`PADS{`BIT_CLEAR}};
			padOeN         <= `OE_OFF;
			clockFreeze    <= `BIT_CLEAR;
			pllLowPower    <= `BIT_CLEAR;
			continuityMode <= `BIT_CLEAR;
		end else begin
			if (selHighz) begin
				padOut <= coreOut;
				padOeN <= `OE_OFF;
			end else if (selExtest) begin
				// held cells drive pads, enable cell one drives
				padOut <= bsrHold_q[`BSR_OUT_LSB+`PADS-1:`BSR_OUT_LSB];
				padOeN <= ~bsrHold_q[`BSR_CTL];
			end else begin
				// core owns the pads in bypass and sample
				padOut <= coreOut;
				padOeN <= coreOeN;
			end
			clockFreeze    <= selHighz;
			pllLowPower    <= selHighz;
			continuityMode <= (ir_q == `IR_CONTINUITY);
		end
	end

	// transceivers never powered down by test logic
	assign lineTransceiversOn = `XCVR_RUN;

endmodule

// *** hw/pin_sync3.v ***
`timescale 1ns/1ns

// ***************************************************************
// Three-stage pin synchroniser with agreement filter
// ***************************************************************
module pin_sync3 #(
	parameter [0:0] RESET_LEVEL = 1'h0
) (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Asynchronous pin and its filtered level
	input  wire pin,
	output reg  level
);

	reg stage1_q;
	reg stage2_q;
	reg stage3_q;

	// Stage one is read only by stage two; level moves once two and three agree
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_q <= RESET_LEVEL;
			stage2_q <= RESET_LEVEL;
			stage3_q <= RESET_LEVEL;
			level    <= RESET_LEVEL;
		end else begin
			stage1_q <= pin;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			if (stage2_q == stage3_q) begin
				level <= stage3_q;
			end
		end
	end

endmodule

// *** include/boundary_scan_test_port_defines.vh ***
`ifndef BOUNDARY_SCAN_TEST_PORT_DEFINES_VH
`define BOUNDARY_SCAN_TEST_PORT_DEFINES_VH

// ***************************************************************
// Instruction register
// ***************************************************************
`define IR_WIDTH      3
`define IR_EXTEST     3'h0
`define IR_SAMPLE     3'h1
`define IR_HIGHZ      3'h5
`define IR_CONTINUITY 3'h6
`define IR_BYPASS     3'h7
// Fixed pattern loaded into the instruction shifter on capture
`define IR_CAPTURE    3'h1

// ***************************************************************
// Boundary scan register layout
// ***************************************************************
// Pads covered by the scan chain
`define PADS          8
`define BSR_LEN       17
`define BSR_IN_LSB    0
`define BSR_OUT_LSB   8
`define BSR_CTL       16

// ***************************************************************
// Reset values
// ***************************************************************
`define BYPASS_CAPTURE 1'h0
`define TDO_IDLE       1'h0
// Active-low enables rest released; plain flags and data rest cleared
`define OE_OFF         1'h1
`define BIT_CLEAR      1'h0
// Line transceivers are never powered down by the test logic
`define XCVR_RUN       1'h1
// Level of an undriven test input, as the pads pull it up
`define PULLUP_LEVEL   1'h1

`endif

// *** tb/boundary_scan_test_port_assertions.sv ***
`timescale 1ns/1ns
`include "boundary_scan_test_port_defines.vh"
// ***************************************************************
// Port checker for the scan test port
// ***************************************************************
module scan_port_checker (
	// Clock and reset
	input wire             clk,
	input wire             rst,
	// Serial test port
	input wire             tck,
	input wire             tdo,
	input wire             tdoOeN,
	// Pads and mode controls
	input wire [`PADS-1:0] coreOut,
	input wire             coreOeN,
	input wire [`PADS-1:0] padOut,
	input wire             padOeN,
	input wire             clockFreeze,
	input wire             pllLowPower,
	input wire             lineTransceiversOn,
	input wire             continuityMode
);
	logic       tckQ;
	logic [3:0] fallAge;

	// Cycles since a test clock fall; saturates so a long idle never wraps
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tckQ    <= 1'h0;
			fallAge <= 4'hf;
		end else begin
			tckQ <= tck;
			if (tckQ && !tck)
				fallAge <= 4'h0;
			else if (fallAge != 4'hf)
				fallAge <= fallAge + 4'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_TDO_FALL: assert property ($changed(tdo) |-> fallAge <= 4'h8)
		else $error("tdo moved away from a test clock fall");
	AST_OE_FALL: assert property ($changed(tdoOeN) |-> fallAge <= 4'h8)
		else $error("tdo enable moved away from a test clock fall");
	AST_MODE_FALL: assert property ($changed({clockFreeze, continuityMode}) |->
		fallAge <= 4'h8)
		else $error("mode output moved without a test clock fall");
	AST_TDO_QUIET: assert property (tdoOeN && $past(tdoOeN) |-> !tdo)
		else $error("tdo not low while released");
	AST_FREEZE_PAIR: assert property (clockFreeze == pllLowPower)
		else $error("clock freeze and pll low power disagree");
	AST_HIGHZ_FLOAT: assert property (clockFreeze |-> padOeN)
		else $error("pads driven in high impedance mode");
	AST_XCVR_ON: assert property (lineTransceiversOn)
		else $error("line transceivers switched off");
	AST_ONE_MODE: assert property (!(clockFreeze && continuityMode))
		else $error("two test modes at once");
	AST_CONT_FOLLOW: assert property ($past(continuityMode, 2) && continuityMode |->
		padOut == $past(coreOut) && padOeN == $past(coreOeN))
		else $error("pads left the core in continuity mode");
	AST_RESET_QUIET: assert property ($fell(rst) |-> tdoOeN [*4])
		else $error("tdo enabled just after reset");
endmodule

// *** tb/boundary_scan_test_port_tb_top.sv ***
`timescale 1ns/1ns
`include "boundary_scan_test_port_defines.vh"
// ***************************************************************
// Self-checking bench for the scan test port
// ***************************************************************
module boundary_scan_test_port_tb_top;
	logic             clk;
	logic             rst;
	logic             tck;
	logic             tms;
	logic             tdi;
	logic             tdo;
	logic             tdoOeN;
	logic [`PADS-1:0] coreOut;
	logic             coreOeN;
	logic [`PADS-1:0] pinIn;
	logic [`PADS-1:0] padOut;
	logic             padOeN;
	logic             clockFreeze;
	logic             pllLowPower;
	logic             lineTransceiversOn;
	logic             continuityMode;
	logic [16:0]      got;
	int               bad_count;
	int               n_checks;
	int               cycles;

	boundary_scan_test_port u_dut (.clk, .rst, .tck, .tms, .tdi, .tdo, .tdoOeN, .coreOut,
		.coreOeN, .pinIn, .padOut, .padOeN, .clockFreeze, .pllLowPower,
		.lineTransceiversOn, .continuityMode);
	scan_ctrl_model u_ctl (.clk, .tck, .tms, .tdi, .tdo, .tdoOeN);

	// Free-running 125 MHz clock
	always #4 clk = ~clk;

	// Hang guard, well past the few thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic testReset();
		chk(17'(tdoOeN), 17'h1);
		chk(17'({clockFreeze, pllLowPower, continuityMode}), 17'h0);
		chk(17'({padOeN, padOut}), 17'({coreOeN, coreOut}));
		u_ctl.tapReset();
		u_ctl.scan(1'h0, 17'h1a5c3, got);
		chk(got, 17'h14b86);
	endtask

	task automatic testModes();
		for (int c = 0; c < 8; c++) begin
			u_ctl.scan(1'h1, 17'(c), got);
			chk(got, 17'h1);
			chk(17'({clockFreeze, pllLowPower, continuityMode}), 17'({c == 5, c == 5, c == 6}));
			chk(17'(lineTransceiversOn), 17'h1);
			if (c == 5)
				chk(17'(padOeN), 17'h1);
			if (c != 0 && c != 5)
				chk(17'({padOeN, padOut}), 17'({coreOeN, coreOut}));
			if (c > 1) begin
				u_ctl.scan(1'h0, 17'h1a5c3, got);
				chk(got, 17'h14b86);
			end
		end
	endtask

	task automatic testExtest();
		u_ctl.scan(1'h1, 17'h1, got);
		u_ctl.scan(1'h0, 17'h16900, got);
		chk(got, {~coreOeN, coreOut, pinIn});
		u_ctl.scan(1'h1, 17'h0, got);
		coreOut = 8'h0f;
		repeat (3) @(negedge clk);
		chk(17'({padOeN, padOut}), 17'h069);
		u_ctl.tapReset();
		chk(17'({padOeN, padOut}), 17'({coreOeN, coreOut}));
	endtask

	// Reset for 8 cycles, then the scenarios in turn
	initial begin
		clk = 1'h0;
		rst = 1'h1;
		bad_count = 0;
		n_checks = 0;
		cycles = 0;
		coreOut = 8'ha5;
		coreOeN = 1'h0;
		pinIn = 8'h3c;
		repeat (8) @(negedge clk);
		rst = 1'h0;
		repeat (2) @(negedge clk);
		testReset();
		testModes();
		testExtest();
		summarize();
	end
endmodule

bind boundary_scan_test_port scan_port_checker u_chk (.clk, .rst, .tck, .tdo, .tdoOeN,
	.coreOut, .coreOeN, .padOut, .padOeN, .clockFreeze, .pllLowPower,
	.lineTransceiversOn, .continuityMode);

// *** tb/scan_ctrl_model.sv ***
`timescale 1ns/1ns
// ***************************************************************
// Board test controller on the serial port
// ***************************************************************
module scan_ctrl_model (
	// Sampling clock
	input  wire  clk,
	// Serial test port
	output logic tck,
	output logic tms,
	output logic tdi,
	input  wire  tdo,
	input  wire  tdoOeN
);
	// pulled-up idle
	// Test clock stands still low; pulled-up lines start at one, and mode select rests low between frames
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end

	// late tdo read
	// One 64 ns period from a fall; tdo is read just before the next fall as it settles late
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		repeat (4) @(negedge clk);
		tck = 1'h1;
		repeat (3) @(negedge clk);
		o = (tdoOeN === 1'h0) ? tdo : 1'hz;
		@(negedge clk);
		tck = 1'h0;
	endtask

	// serial chain
	// Idle to idle scan, low bit first; 3 bits for instruction, 17 for data
	task automatic scan(input logic ir, input logic [16:0] din, output logic [16:0] dout);
		logic b;
		dout = '0;
		@(negedge clk);
		step(1'h1, 1'h1, b);
		if (ir)
			step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
		step(1'h0, 1'h1, b);
		for (int i = 0; i < (ir ? 3 : 17); i++)
			step(i == (ir ? 2 : 16), din[i], dout[i]);
		step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
	endtask

	task automatic tapReset();
		logic b;
		@(negedge clk);
		repeat (5) step(1'h1, 1'h1, b);
		step(1'h0, 1'h1, b);
	endtask
endmodule
